// *** tb/can_bus_model.sv ***
// Bus side model: idle recessive line with a dominant burst on request.
`timescale 1ns/100ps
`default_nettype none
module can_bus_model
(
  // Clock and trigger
  input  wire logic pclk,
  input  wire logic burst,
  // Receive line
  output var  logic bus_rx_pin
);
  logic [4:0] left = 5'h00;
  always @(posedge pclk)
    if (burst)
      left <= 5'h10;
    else if (left != 5'h00)
      left <= left - 5'h01;
  assign bus_rx_pin = (left == 5'h00);
endmodule
`default_nettype wire

// *** tb/can_ctl_props.sv ***
// Port checker for the CAN mode control block.
`timescale 1ns/100ps
`default_nettype none
module can_ctl_props
#(
  parameter int bit_cycles = 50
)
(
  // Clock, reset and bus handshake
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Pins, engine and power
  input wire logic bus_tx_pin,
  input wire logic engine_tx_bit,
  input wire logic engine_frame_acked,
  input wire logic engine_abort,
  input wire logic stamp_write,
  input wire logic cpu_wait,
  input wire logic cpu_stop,
  input wire logic bus_clock_gate
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_tx_recessive: assert property ($past(engine_tx_bit) |-> bus_tx_pin)
    else $error("recessive bit driven dominant");
  chk_init_tx: assert property (engine_abort |-> bus_tx_pin)
    else $error("transmit pin dominant during init");
  chk_stop_tx: assert property (cpu_stop |=> bus_tx_pin)
    else $error("transmit pin dominant in stop");
  chk_stop_gate: assert property (cpu_stop |=> !bus_clock_gate)
    else $error("interface clocked in stop");
  chk_run_gate: assert property (!cpu_stop && !cpu_wait |=> bus_clock_gate)
    else $error("interface gated while running");
  chk_stamp_cause: assert property (stamp_write |-> $past(engine_frame_acked))
    else $error("stamp stored without acknowledge");
  chk_init_stamp: assert property (engine_abort[*4] ##0 engine_frame_acked |=> !stamp_write)
    else $error("stamp stored in init mode");
  chk_ready_access: assert property (pready |-> psel && penable ##1 !pready)
    else $error("answer outside a one cycle access");
  chk_error_ready: assert property (pslverr |-> pready)
    else $error("error flag without answer");
  cover property (stamp_write);
  cover property (pslverr);
  cover property (cpu_wait && !bus_clock_gate);
endmodule
bind can_mode_control_status can_ctl_props #(.bit_cycles(bit_cycles)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .bus_tx_pin(bus_tx_pin), .engine_tx_bit(engine_tx_bit),
  .engine_frame_acked(engine_frame_acked), .engine_abort(engine_abort),
  .stamp_write(stamp_write), .cpu_wait(cpu_wait), .cpu_stop(cpu_stop),
  .bus_clock_gate(bus_clock_gate)
);
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking testbench of the CAN mode control block.
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        bus_rx_pin;
  logic        bus_tx_pin;
  logic        tx_bit = 1'b1;
  logic        tx_prev = 1'b1;
  logic [15:0] stamp;
  logic [2:0]  ev = 3'h0;
  logic        rx_on = 1'b0;
  logic        synced = 1'b0;
  logic        empty = 1'b0;
  logic        cpu_wait = 1'b0;
  logic        cpu_stop = 1'b0;
  logic        gate;
  logic        irq;
  logic [32:0] exp_q[$];
  integer      seed = 32'h1bb3;
  integer      err_count = 0;
  integer      total_checks = 0;
  logic [7:0]  w;
  always #20 pclk = ~pclk;
  always @(posedge pclk)
  begin
    tx_bit  <= 1'($random(seed));
    tx_prev <= tx_bit;
  end
  can_mode_control_status #(.bit_cycles(4)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus_rx_pin(bus_rx_pin), .bus_tx_pin(bus_tx_pin), .engine_tx_bit(tx_bit),
    .engine_receiving(rx_on), .engine_synchronized(synced), .engine_frame_valid(ev[0]),
    .engine_frame_acked(ev[1]), .tx_buffers_empty(empty), .engine_abort(),
    .stamp_value(stamp), .stamp_write(), .cpu_wait(cpu_wait), .cpu_stop(cpu_stop),
    .bus_clock_gate(gate), .irq(irq)
  );
  can_bus_model bus (.pclk(pclk), .burst(ev[2]), .bus_rx_pin(bus_rx_pin));
  task cmp(input logic [32:0] got, input logic [32:0] e);
    total_checks++;
    if (got !== e)
    begin
      $display("unexpected at %0t: got %h expected %h", $time, got, e);
      err_count++;
    end
  endtask
  task flag(input logic g, input logic e);
    cmp({32'h0, g}, {32'h0, e});
  endtask
  // The master holds every request until pready is seen high.
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task pulse(input int i);
    @(posedge pclk);
    ev[i] <= 1'b1;
    @(posedge pclk);
    ev[i] <= 1'b0;
  endtask
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
      cmp({pslverr, prdata}, exp_q.pop_front());
  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    #200000;
    err_count++;
    end_of_test;
  end
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h000, 33'h0);
    flag(bus_tx_pin, tx_prev);
    w = 8'($random(seed)) & 8'h7c;
    apb(1'b1, 12'h000, {24'h0, w});
    rd(12'h000, {25'h0, w & 8'h2c});
    rx_on <= 1'b1;
    synced <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(12'h000, {25'h0, (w & 8'h2c) | 8'h50});
    rx_on <= 1'b0;
    synced <= 1'b0;
    apb(1'b1, 12'h000, 32'h0);
    $display("status test done");
    apb(1'b1, 12'h010, 32'h1);
    pulse(0);
    repeat (3) @(posedge pclk);
    flag(irq, 1'b1);
    apb(1'b1, 12'h000, 32'h0);
    rd(12'h000, 33'h80);
    apb(1'b1, 12'h000, 32'h80);
    rd(12'h000, 33'h0);
    rd(12'h00c, 33'h1);
    repeat (3) @(posedge pclk);
    flag(irq, 1'b0);
    apb(1'b1, 12'h010, 32'h0);
    pulse(0);
    repeat (3) @(posedge pclk);
    flag(irq, 1'b0);
    rd(12'h00c, 33'h1);
    apb(1'b1, 12'h000, 32'h80);
    $display("frame test done");
    apb(1'b1, 12'h000, 32'h08);
    repeat (20) @(posedge pclk);
    pulse(1);
    repeat (2) @(posedge pclk);
    // The timer ran for 21 edges at 4 cycles a bit, so 5 or 6 ticks.
    flag(stamp == 16'h0005 || stamp == 16'h0006, 1'b1);
    rd(12'h00c, 33'h4);
    apb(1'b1, 12'h000, 32'h0);
    repeat (2) @(posedge pclk);
    rd(12'h008, 33'h0);
    $display("timer test done");
    apb(1'b1, 12'h000, 32'h2d);
    repeat (5) @(posedge pclk);
    pulse(1);
    rd(12'h000, 33'h05);
    rd(12'h004, 33'h1);
    flag(bus_tx_pin, 1'b1);
    apb(1'b1, 12'h000, 32'h20);
    repeat (3) @(posedge pclk);
    rd(12'h000, 33'h04);
    rd(12'h00c, 33'h0);
    rd(12'h0f0, 33'h1_0000_0000);
    $display("init test done");
    apb(1'b1, 12'h000, 32'h20);
    cpu_wait <= 1'b1;
    repeat (3) @(posedge pclk);
    flag(gate, 1'b0);
    flag(bus_tx_pin, 1'b1);
    cpu_wait <= 1'b0;
    cpu_stop <= 1'b1;
    repeat (3) @(posedge pclk);
    cpu_stop <= 1'b0;
    apb(1'b1, 12'h000, 32'h0);
    cpu_wait <= 1'b1;
    repeat (3) @(posedge pclk);
    flag(gate, 1'b1);
    rd(12'h014, 33'h1);
    cpu_wait <= 1'b0;
    $display("wait test done");
    apb(1'b1, 12'h000, 32'h06);
    repeat (4) @(posedge pclk);
    rd(12'h004, 33'h0);
    empty <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(12'h004, 33'h2);
    pulse(2);
    repeat (40) @(posedge pclk);
    rd(12'h000, 33'h4);
    rd(12'h00c, 33'h2);
    $display("sleep test done");
    end_of_test;
  end
endmodule
`default_nettype wire

// *** verilog/can_ctl_pkg.sv ***
// Package with register map, field positions and timing counts of the CAN mode control block.
`default_nettype none
package can_ctl_pkg;
  // ***************************************************************
  // Register offsets (byte addresses on APB)
  // ***************************************************************
  localparam logic [11:0] control_zero_addr = 12'h000;
  localparam logic [11:0] control_one_addr  = 12'h004;
  localparam logic [11:0] stamp_addr        = 12'h008;
  localparam logic [11:0] irq_status_addr   = 12'h00c;
  localparam logic [11:0] irq_mask_addr     = 12'h010;
  localparam logic [11:0] mode_addr         = 12'h014;
  // ***************************************************************
  // Control register zero fields
  // ***************************************************************
  localparam int frame_received_bit = 7;
  localparam int receiver_active_bit = 6;
  localparam int stop_in_wait_bit   = 5;
  localparam int synchronized_bit   = 4;
  localparam int timer_enable_bit   = 3;
  localparam int wakeup_enable_bit  = 2;
  localparam int sleep_request_bit  = 1;
  localparam int init_request_bit   = 0;
  localparam logic [7:0] control_zero_reset = 8'h00;
  // ***************************************************************
  // Control register one fields (acknowledges and loopback)
  // ***************************************************************
  localparam int loopback_bit     = 2;
  localparam int sleep_ack_bit    = 1;
  localparam int init_ack_bit     = 0;
  // ***************************************************************
  // Interrupt status fields
  // ***************************************************************
  localparam int irq_frame_bit    = 0;
  localparam int irq_wakeup_bit   = 1;
  localparam int irq_stamp_bit    = 2;
  localparam int irq_width        = 3;
  // ***************************************************************
  // Pin levels and timing
  // ***************************************************************
  localparam logic level_dominant  = 1'b0;
  localparam logic level_recessive = 1'b1;
  localparam int   clock_hz        = 25_000_000;
  localparam int   bit_rate_hz     = 500_000;
  localparam int   bit_cycles      = clock_hz / bit_rate_hz;
  localparam int   stamp_width     = 16;
endpackage
`default_nettype wire

// *** verilog/can_ctl_sync.sv ***
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/100ps
`default_nettype none
module can_ctl_sync
#(
  parameter logic reset_level = 1'b1
)
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Raw and filtered level
  input  wire logic raw_in,
  output var  logic clean_out
);
  logic stage_one;
  logic stage_two;
  logic stage_three;

  // ***************************************************************
  // Only the second stage reads the first one.
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stage_one   <= reset_level;
      stage_two   <= reset_level;
      stage_three <= reset_level;
      clean_out   <= reset_level;
    end
    else
    begin
      stage_one   <= raw_in;
      stage_two   <= stage_one;
      stage_three <= stage_two;
      if (stage_two == stage_three)
        clean_out <= stage_three;
    end
  end
endmodule
`default_nettype wire

// *** verilog/can_mode_control_status.sv ***
// CAN controller mode control and status register with APB access.
//
// How it works
// - Transmit pin low means dominant, high means recessive.
// - Init mode holds control register reset except wake, init, sleep bits.
// - Writes accepted only with init request and acknowledge both low; status bits read-only; init request also writable in init.
// - Frame received flag bit 7 set by valid frame, cleared by writing one.
// - Receiver active bit 6 high while receiving, low transmitting or idle.
// - Stop-in-wait bit 5 freezes bus interface clocks during wait mode.
// - Read-only bit 4 shows synchronisation to the bus.
// - Timer enable bit 3 runs 16-bit counter once per bit time.
// - On acknowledge, counter value stored as stamp of active buffer.
// - Counter clears when disabled; timer enable forced low in init.
// - Wake-up enable bit 2 lets bus traffic end sleep mode.
// - Init request bit 0 enters init at once, aborting transfer, losing sync.
// - Transmit pin forced recessive in stop, or wait with stop-in-wait.
// - Sleep request bit 1 served only when bus idle; acknowledged separately.
`timescale 1ns/100ps
`default_nettype none
module can_mode_control_status
#(
  parameter int bit_cycles = can_ctl_pkg::bit_cycles
)
(
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // CAN pins
  input  wire logic        bus_rx_pin,
  output var  logic        bus_tx_pin,
  // Protocol engine
  input  wire logic        engine_tx_bit,
  input  wire logic        engine_receiving,
  input  wire logic        engine_synchronized,
  input  wire logic        engine_frame_valid,
  input  wire logic        engine_frame_acked,
  input  wire logic        tx_buffers_empty,
  output var  logic        engine_abort,
  output var  logic [15:0] stamp_value,
  output var  logic        stamp_write,
  // System power modes
  input  wire logic        cpu_wait,
  input  wire logic        cpu_stop,
  output var  logic        bus_clock_gate,
  // Interrupt
  output var  logic        irq
);
  localparam int fr  = can_ctl_pkg::frame_received_bit;
  localparam int sw  = can_ctl_pkg::stop_in_wait_bit;
  localparam int te  = can_ctl_pkg::timer_enable_bit;
  localparam int we  = can_ctl_pkg::wakeup_enable_bit;
  localparam int sr  = can_ctl_pkg::sleep_request_bit;
  localparam int ir  = can_ctl_pkg::init_request_bit;
  localparam int iw  = can_ctl_pkg::irq_width;

  logic [7:0]            control_zero;
  logic                  init_acknowledge;
  logic                  sleep_acknowledge;
  logic                  loopback;
  logic                  receiver_active;
  logic                  bus_synchronized;
  logic [15:0]           stamp_counter;
  logic [15:0]           bit_count;
  logic [iw-1:0]         irq_status;
  logic [iw-1:0]         irq_mask;
  logic                  rx_clean;
  logic                  rx_prev;

  // ***************************************************************
  // Pin synchroniser
  // ***************************************************************
  can_ctl_sync #(.reset_level(can_ctl_pkg::level_recessive)) rx_sync
  (
    .pclk      (pclk),
    .presetn   (presetn),
    .raw_in    (bus_rx_pin),
    .clean_out (rx_clean)
  );

  // ***************************************************************
  // Decoding
  // ***************************************************************
  function automatic logic hit(input logic [11:0] a, input logic [11:0] target);
    hit = (a == target);
  endfunction

  wire access        = psel && penable && pready;
  wire wr            = access && pwrite;
  wire rd            = access && !pwrite;
  wire sel_ctl0      = hit(paddr, can_ctl_pkg::control_zero_addr);
  wire sel_ctl1      = hit(paddr, can_ctl_pkg::control_one_addr);
  wire sel_stamp     = hit(paddr, can_ctl_pkg::stamp_addr);
  wire sel_status    = hit(paddr, can_ctl_pkg::irq_status_addr);
  wire sel_mask      = hit(paddr, can_ctl_pkg::irq_mask_addr);
  wire sel_mode      = hit(paddr, can_ctl_pkg::mode_addr);
  wire mapped        = sel_ctl0 | sel_ctl1 | sel_stamp | sel_status | sel_mask | sel_mode;
  wire in_init       = control_zero[ir] && init_acknowledge;
  // Wait with stop-in-wait freezes the whole bus interface, so register accesses stop too.
  wire frozen        = (cpu_wait && control_zero[sw]) || cpu_stop;
  wire wr_ctl0       = wr && sel_ctl0 && !frozen;
  // Writes stay shut until both init request and acknowledge have dropped.
  wire wr_ok_normal  = wr_ctl0 && !control_zero[ir] && !init_acknowledge;
  wire answer        = psel && !pready && !frozen;
  wire bus_activity  = (rx_prev != rx_clean) && (rx_clean == can_ctl_pkg::level_dominant);
  wire wake_event    = sleep_acknowledge && control_zero[we] && bus_activity;
  wire bus_idle      = !engine_receiving && tx_buffers_empty;
  wire bit_tick      = (bit_count == 16'(bit_cycles - 1));
  wire [iw-1:0] irq_events = {engine_frame_acked && control_zero[te],
                              wake_event, engine_frame_valid};
  // Only bits already shown to software are cleared, so an event in the read cycle survives.
  wire [iw-1:0] status_taken = (rd && sel_status) ? prdata[iw-1:0] : {iw{1'b0}};
  wire [7:0] ctl0_view = {control_zero[7], receiver_active, control_zero[5],
                          bus_synchronized, control_zero[3:0]};
  wire [31:0] read_mux =
      sel_ctl0   ? {24'h000000, ctl0_view} :
      sel_ctl1   ? {29'h00000000, loopback, sleep_acknowledge, init_acknowledge} :
      sel_stamp  ? {16'h0000, stamp_counter} :
      sel_status ? {29'h00000000, irq_status} :
      sel_mask   ? {29'h00000000, irq_mask} :
      sel_mode   ? {30'h00000000, cpu_stop, cpu_wait} :
      32'h00000000;

  // ***************************************************************
  // Control register zero
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      control_zero <= can_ctl_pkg::control_zero_reset;
    else if (in_init)
    begin
      control_zero[7:3] <= 5'h00;
      if (wr_ctl0)
        control_zero[ir] <= pwdata[ir];
    end
    else
    begin
      // A new frame wins over a clearing write in the same cycle.
      if (engine_frame_valid)
        control_zero[fr] <= 1'b1;
      else if (wr_ok_normal && pwdata[fr])
        control_zero[fr] <= 1'b0;
      if (wr_ok_normal)
      begin
        control_zero[sw] <= pwdata[sw];
        control_zero[te] <= pwdata[te];
        control_zero[we] <= pwdata[we];
        // Init request may not be cleared before it is acknowledged.
        control_zero[ir] <= pwdata[ir] | (control_zero[ir] & !init_acknowledge);
        if (!(control_zero[sr] && !sleep_acknowledge))
          control_zero[sr] <= pwdata[sr];
      end
      if (wake_event)
        control_zero[sr] <= 1'b0;
    end
  end

  // ***************************************************************
  // Mode handshakes
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      init_acknowledge  <= 1'b0;
      sleep_acknowledge <= 1'b0;
      loopback          <= 1'b0;
    end
    else
    begin
      init_acknowledge  <= control_zero[ir];
      sleep_acknowledge <= control_zero[sr] && (sleep_acknowledge || bus_idle);
      if (wr && sel_ctl1 && in_init)
        loopback <= pwdata[can_ctl_pkg::loopback_bit];
    end
  end

  // ***************************************************************
  // Receiver status and pin edge
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      receiver_active   <= 1'b0;
      bus_synchronized  <= 1'b0;
      rx_prev           <= can_ctl_pkg::level_recessive;
    end
    else
    begin
      // Status bits follow the engine and are forced low by init request; bus writes cannot set them.
      receiver_active   <= engine_receiving && !control_zero[ir];
      bus_synchronized  <= engine_synchronized && !control_zero[ir];
      rx_prev           <= rx_clean;
    end
  end

  // ***************************************************************
  // Bit time divider
  // ***************************************************************
  // Free-running, so the first tick after enabling may come up to one bit time early.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bit_count <= 16'h0000;
    else
      bit_count <= bit_tick ? 16'h0000 : bit_count + 16'h0001;
  end

  // ***************************************************************
  // Time-stamp timer
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stamp_counter <= 16'h0000;
      stamp_value   <= 16'h0000;
      stamp_write   <= 1'b0;
    end
    else
    begin
      stamp_write <= engine_frame_acked && control_zero[te];
      if (engine_frame_acked && control_zero[te])
        stamp_value <= stamp_counter;
      if (!control_zero[te])
        stamp_counter <= 16'h0000;
      else if (bit_tick)
        stamp_counter <= stamp_counter + 16'h0001;
    end
  end

  // ***************************************************************
  // Interrupt status and mask; a read clears, a new event wins
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_status <= '0;
      irq_mask   <= '0;
      irq        <= 1'b0;
    end
    else
    begin
      irq_status <= (irq_status & ~status_taken) | irq_events;
      if (wr && sel_mask)
        irq_mask <= pwdata[iw-1:0];
      irq        <= |(irq_status & irq_mask);
    end
  end

  // ***************************************************************
  // APB answer
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      // A frozen interface holds off the answer until wait or stop ends.
      pready  <= answer;
      pslverr <= answer && !mapped;
      prdata  <= answer ? read_mux : 32'h00000000;
    end
  end

  // ***************************************************************
  // Pin drivers and engine controls
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bus_tx_pin     <= can_ctl_pkg::level_recessive;
      engine_abort   <= 1'b0;
      bus_clock_gate <= 1'b1;
    end
    else
    begin
      engine_abort   <= control_zero[ir];
      bus_clock_gate <= !frozen;
      if (frozen || control_zero[ir] || sleep_acknowledge)
        bus_tx_pin <= can_ctl_pkg::level_recessive;
      else
        bus_tx_pin <= engine_tx_bit;
    end
  end
endmodule
`default_nettype wire
